// >>> hw/sbst_params.svh
`ifndef SBST_PARAMS_SVH
`define SBST_PARAMS_SVH

// ****************************************
// register lengths
// ****************************************
`define SBST_IR_W      3
`define SBST_ID_W      32
`define SBST_BS_W      109

// ****************************************
// instruction codes
// ****************************************
`define SBST_OP_EXTEST  3'h0
`define SBST_OP_IDCODE  3'h1
`define SBST_OP_SAMPZ   3'h2
`define SBST_OP_SAMPLE  3'h4
`define SBST_OP_BYPASS  3'h7

// ****************************************
// capture and reset values, sync stage count
// ****************************************
`define SBST_IR_CAPT    3'h1
`define SBST_SKIP_CAPT  1'h0
`define SBST_IR_RST     `SBST_OP_IDCODE
`define SBST_SYNC_N     3

`endif

// >>> hw/sbst_pkg.sv
`include "sbst_params.svh"

package sbst_pkg;

  // ****************************************
  // test controller states
  // ****************************************
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } sbst_state_e;

  // ****************************************
  // state of the test clock domain
  // ****************************************
  typedef struct packed {
    sbst_state_e            st;
    logic [`SBST_IR_W-1:0]  ir_sh;
    logic [`SBST_IR_W-1:0]  ir;
    logic                   skip;
    logic [`SBST_ID_W-1:0]  id_sh;
    logic [`SBST_BS_W-1:0]  bs_sh;
    logic [`SBST_BS_W-1:0]  bs_upd;
    logic                   drive_en;
    logic                   hiz;
    logic                   odt_off;
    logic [`SBST_BS_W-1:0]  pin_s1;
    logic [`SBST_BS_W-1:0]  pin_s2;
    logic [`SBST_BS_W-1:0]  pin_s3;
    logic [`SBST_BS_W-1:0]  pin_q;
  } sbst_tck_s;

  // ****************************************
  // falling edge output stage
  // ****************************************
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sbst_neg_s;

  // ****************************************
  // system clock domain
  // ****************************************
  typedef struct packed {
    logic [`SBST_SYNC_N-1:0] drive_sy;
    logic [`SBST_SYNC_N-1:0] hiz_sy;
    logic [`SBST_SYNC_N-1:0] odt_sy;
    logic                    extest_mode;
    logic                    out_hiz;
    logic                    odt_dis;
  } sbst_sys_s;

endpackage : sbst_pkg

// >>> hw/sbst_tap.sv
`timescale 1ns/100ps
`include "sbst_params.svh"

// Summary of operation
// - instruction, skip, identity, pin chain registers shiftable
// - extest drives output pins, captures inputs
// - update-ir with extest enables pin drivers
// - idcode captures identity word, then shifts it
// - instruction is idcode after reset
// - sample-z forces memory outputs high impedance
// - sample-z captures inputs, shifts pin chain
// - sample captures pins without forcing high-z
// - sample shifts pin chain for preload
// - asynchronous pin sampling is harmless
// - bypass routes through one-bit skip stage
// - extest need not preserve output register
// - termination off under extest, sample-z, sample
// - five tms-high edges or power-up reset
// - inputs on rising edge, tdo on falling
module sbst_tap
  import sbst_pkg::*;
#(
  // arbitrary identity value, lsb kept at one
  parameter logic [`SBST_ID_W-1:0] ID_VALUE = 32'h0000_0001
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  test_clk,
  input  wire logic                  mode_sel,
  input  wire logic                  test_din,
  output logic                       test_dout,
  output logic                       test_dout_oe,
  input  wire logic [`SBST_BS_W-1:0] pin_level,
  output logic      [`SBST_BS_W-1:0] pin_drive,
  output logic                       pin_drive_en,
  output logic                       extest_mode,
  output logic                       ram_out_hiz,
  output logic                       odt_disable
);

  // ****************************************
  // state transition of the controller
  // ****************************************
  function automatic sbst_state_e sbst_next(input sbst_state_e s, input logic m);
    sbst_state_e n;
    n = s;
    case (s)
      ST_RESET:  n = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  n = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: n = m ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  n = m ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: n = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: n = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: n = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  n = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: n = m ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  n = m ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: n = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
      default:   n = ST_RESET;
    endcase
    return n;
  endfunction : sbst_next

  // instructions that put the pin chain on the serial path
  function automatic logic sbst_on_chain(input logic [`SBST_IR_W-1:0] c);
    return (c == `SBST_OP_EXTEST) || (c == `SBST_OP_SAMPZ) || (c == `SBST_OP_SAMPLE);
  endfunction : sbst_on_chain

  // ****************************************
  // test clock domain
  // ****************************************
  sbst_tck_s t_r;
  sbst_tck_s t_nxt;
  logic      dr_bit;

  // serial path selected by the loaded instruction
  always_comb begin
    case (t_r.ir)
      `SBST_OP_IDCODE: dr_bit = t_r.id_sh[0];
      `SBST_OP_EXTEST,
      `SBST_OP_SAMPZ,
      `SBST_OP_SAMPLE: dr_bit = t_r.bs_sh[0];
      default:         dr_bit = t_r.skip;
    endcase
  end

  always_comb begin
    t_nxt    = t_r;
    t_nxt.st = sbst_next(t_r.st, mode_sel);
    // pin levels pass three stages; a bit moves once the second and third agree
    t_nxt.pin_s1 = pin_level;
    t_nxt.pin_s2 = t_r.pin_s1;
    t_nxt.pin_s3 = t_r.pin_s2;
    t_nxt.pin_q  = (t_r.pin_q & (t_r.pin_s2 ^ t_r.pin_s3)) |
                   (t_r.pin_s3 & ~(t_r.pin_s2 ^ t_r.pin_s3));
    case (t_r.st)
      ST_RESET: begin
        t_nxt.ir = `SBST_IR_RST;
      end
      ST_CAP_IR: begin
        t_nxt.ir_sh = `SBST_IR_CAPT;
      end
      ST_SH_IR: begin
        t_nxt.ir_sh = {test_din, t_r.ir_sh[`SBST_IR_W-1:1]};
      end
      ST_UPD_IR: begin
        t_nxt.ir = t_r.ir_sh;
      end
      ST_CAP_DR: begin
        t_nxt.skip = `SBST_SKIP_CAPT;
        if (t_r.ir == `SBST_OP_IDCODE) begin
          t_nxt.id_sh = ID_VALUE;
        end
        if (sbst_on_chain(t_r.ir)) begin
          // a pin moving near the capture only gives an unrepeatable bit
          t_nxt.bs_sh = t_r.pin_q;
        end
      end
      ST_SH_DR: begin
        t_nxt.skip  = test_din;
        t_nxt.id_sh = {test_din, t_r.id_sh[`SBST_ID_W-1:1]};
        t_nxt.bs_sh = {test_din, t_r.bs_sh[`SBST_BS_W-1:1]};
      end
      ST_UPD_DR: begin
        if (t_r.ir == `SBST_OP_EXTEST || t_r.ir == `SBST_OP_SAMPLE) begin
          t_nxt.bs_upd = t_r.bs_sh;
        end
      end
      default: begin
      end
    endcase
    // pin modes follow the instruction that is in force
    t_nxt.drive_en = (t_nxt.ir == `SBST_OP_EXTEST);
    t_nxt.hiz      = (t_nxt.ir == `SBST_OP_SAMPZ);
    t_nxt.odt_off  = sbst_on_chain(t_nxt.ir);
  end

  always_ff @(posedge test_clk or negedge rst_b) begin
    if (!rst_b) begin
      t_r        <= '0;
      t_r.st     <= ST_RESET;
      t_r.ir     <= `SBST_IR_RST;
      t_r.ir_sh  <= `SBST_IR_CAPT;
    end else begin
      t_r <= t_nxt;
    end
  end

  // ****************************************
  // falling edge data output
  // ****************************************
  sbst_neg_s n_r;
  sbst_neg_s n_nxt;

  always_comb begin
    n_nxt        = n_r;
    n_nxt.tdo_oe = (t_r.st == ST_SH_IR) || (t_r.st == ST_SH_DR);
    if (t_r.st == ST_SH_IR) begin
      n_nxt.tdo = t_r.ir_sh[0];
    end else if (t_r.st == ST_SH_DR) begin
      n_nxt.tdo = dr_bit;
    end
  end

  always_ff @(negedge test_clk or negedge rst_b) begin
    if (!rst_b) begin
      n_r <= '0;
    end else begin
      n_r <= n_nxt;
    end
  end

  assign test_dout    = n_r.tdo;
  assign test_dout_oe = n_r.tdo_oe;
  assign pin_drive    = t_r.bs_upd;
  assign pin_drive_en = t_r.drive_en;

  // ****************************************
  // system clock domain
  // ****************************************
  sbst_sys_s s_r;
  sbst_sys_s s_nxt;

  // a level change counts once the second and third stages agree
  always_comb begin
    s_nxt          = s_r;
    s_nxt.drive_sy = {s_r.drive_sy[`SBST_SYNC_N-2:0], t_r.drive_en};
    s_nxt.hiz_sy   = {s_r.hiz_sy[`SBST_SYNC_N-2:0], t_r.hiz};
    s_nxt.odt_sy   = {s_r.odt_sy[`SBST_SYNC_N-2:0], t_r.odt_off};
    if (s_r.drive_sy[2] == s_r.drive_sy[1]) begin
      // memory output register may be lost while extest holds
      s_nxt.extest_mode = s_r.drive_sy[2];
    end
    if (s_r.hiz_sy[2] == s_r.hiz_sy[1]) begin
      s_nxt.out_hiz = s_r.hiz_sy[2];
    end
    if (s_r.odt_sy[2] == s_r.odt_sy[1]) begin
      s_nxt.odt_dis = s_r.odt_sy[2];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign extest_mode = s_r.extest_mode;
  assign ram_out_hiz = s_r.out_hiz;
  assign odt_disable = s_r.odt_dis;

endmodule : sbst_tap

// >>> verif/sbst_tap_checker.sv
`timescale 1ns/100ps
module sbst_tap_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic test_clk,
  input wire logic mode_sel,
  input wire logic test_dout,
  input wire logic test_dout_oe,
  input wire logic pin_drive_en,
  input wire logic extest_mode,
  input wire logic ram_out_hiz,
  input wire logic odt_disable
);
  // ****************************************
  // test clock domain
  // ****************************************
  sequence s_five;
    mode_sel [*5];
  endsequence
  property p_five_reset;
    @(posedge test_clk) disable iff (!rst_b) s_five |-> ##2 !pin_drive_en && !test_dout_oe;
  endproperty
  a_five_reset: assert property (p_five_reset) else $error("test logic not reset by mode_sel");

  // ****************************************
  // system clock domain
  // ****************************************
  property p_neg_out;
    @(posedge sys_clk) disable iff (!rst_b)
      $past(test_clk) && test_clk |-> $stable(test_dout) && $stable(test_dout_oe);
  endproperty
  a_neg_out: assert property (p_neg_out) else $error("test_dout moved while test_clk high");
  property p_ext_on;
    @(posedge sys_clk) disable iff (!rst_b) $rose(pin_drive_en) |-> ##[2:5] extest_mode;
  endproperty
  a_ext_on: assert property (p_ext_on) else $error("extest_mode late");
  property p_ext_off;
    @(posedge sys_clk) disable iff (!rst_b) $fell(pin_drive_en) |-> ##[2:5] !extest_mode;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("extest_mode stuck");
  property p_ext_src;
    @(posedge sys_clk) disable iff (!rst_b) $rose(extest_mode) |-> $past(pin_drive_en, 2);
  endproperty
  a_ext_src: assert property (p_ext_src) else $error("extest_mode without pin drive");
  property p_hiz_odt;
    @(posedge sys_clk) disable iff (!rst_b) ram_out_hiz && $past(ram_out_hiz) |-> odt_disable;
  endproperty
  a_hiz_odt: assert property (p_hiz_odt) else $error("termination on while high-z");
  property p_hiz_src;
    @(posedge sys_clk) disable iff (!rst_b) $rose(ram_out_hiz) |-> !pin_drive_en;
  endproperty
  a_hiz_src: assert property (p_hiz_src) else $error("high-z raised under extest");
  property p_rst_idle;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(rst_b) |-> !extest_mode && !ram_out_hiz && !odt_disable && !pin_drive_en;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("modes active after reset");
endmodule : sbst_tap_checker

bind sbst_tap sbst_tap_checker chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .test_clk(test_clk), .mode_sel(mode_sel),
  .test_dout(test_dout), .test_dout_oe(test_dout_oe), .pin_drive_en(pin_drive_en),
  .extest_mode(extest_mode), .ram_out_hiz(ram_out_hiz), .odt_disable(odt_disable)
);

// >>> verif/sbst_jtag_ctl.sv
`timescale 1ns/100ps
`include "sbst_params.svh"
module sbst_jtag_ctl (
  output logic      test_clk,
  output logic      mode_sel,
  output logic      test_din,
  input  wire logic tdo_line
);
  // clock stands still low between frames, pulled-up lines idle high
  initial begin
    test_clk = 1'h0;
    mode_sel = 1'h1;
    test_din = 1'h1;
  end
  // one cycle: drive while low, sample the data out just before rising
  task automatic step(input logic m, input logic d, output logic o);
    mode_sel <= m;
    test_din <= d;
    #32;
    o = tdo_line;
    test_clk <= 1'h1;
    #32;
    test_clk <= 1'h0;
  endtask : step
  task automatic tlr();
    logic o;
    repeat (5) step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
  endtask : tlr
  // from idle, shift n bits lsb first through ir or dr, back to idle
  task automatic shift(input logic ir, input int n, input logic [`SBST_BS_W-1:0] d,
                       output logic [`SBST_BS_W-1:0] q);
    logic o;
    q = '0;
    step(1'h1, 1'h1, o);
    if (ir) step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    step(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    mode_sel <= 1'h1;
    test_din <= 1'h1;
    // released lines rest before the next frame drives them again
    #32;
  endtask : shift
endmodule : sbst_jtag_ctl

// >>> verif/test_sbst_tap.sv
`timescale 1ns/100ps
`include "sbst_params.svh"
module test_sbst_tap;
  import sbst_pkg::*;
  localparam logic [`SBST_ID_W-1:0] ID = 32'h5A3C_96E1; // arbitrary value, lsb one
  localparam logic [`SBST_BS_W-1:0] PA = {1'h1, {27{4'hA}}};
  localparam logic [`SBST_BS_W-1:0] PB = {1'h0, {27{4'h3}}};
  localparam logic [`SBST_BS_W-1:0] PC = {1'h1, {27{4'hC}}};
  logic                  sys_clk, rst_b, o;
  logic [`SBST_BS_W-1:0] pin_level, pin_drive, q;
  logic                  test_dout, test_dout_oe, pin_drive_en;
  logic                  extest_mode, ram_out_hiz, odt_disable;
  wire logic             test_clk, mode_sel, test_din, tdo_line;
  int                    fails, checked;

  sbst_tap #(.ID_VALUE(ID)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .test_clk(test_clk),
    .mode_sel(mode_sel), .test_din(test_din), .test_dout(test_dout),
    .test_dout_oe(test_dout_oe), .pin_level(pin_level), .pin_drive(pin_drive),
    .pin_drive_en(pin_drive_en), .extest_mode(extest_mode), .ram_out_hiz(ram_out_hiz),
    .odt_disable(odt_disable));
  sbst_jtag_ctl ctl (.test_clk(test_clk), .mode_sel(mode_sel), .test_din(test_din),
    .tdo_line(tdo_line));
  // a released data out does not keep its last level
  assign tdo_line = test_dout_oe ? test_dout : !test_dout;

  initial sys_clk = 1'h0;
  always #2 sys_clk = ~sys_clk;

  task automatic chk(string what, logic [`SBST_BS_W-1:0] seen, logic [`SBST_BS_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic load_ir(logic [`SBST_IR_W-1:0] code);
    ctl.shift(1'h1, `SBST_IR_W, code, q);
    chk("ir capture", q[2:0], `SBST_IR_CAPT);
    #400;
  endtask : load_ir
  task automatic modes(logic e, logic h, logic t);
    chk("pin_drive_en", pin_drive_en, e);
    chk("extest_mode", extest_mode, e);
    chk("ram_out_hiz", ram_out_hiz, h);
    chk("odt_disable", odt_disable, t);
  endtask : modes
  // pins change on a system edge, then step off it
  task automatic set_pins(logic [`SBST_BS_W-1:0] v);
    @(posedge sys_clk);
    pin_level <= v;
    #0.7;
  endtask : set_pins

  task automatic t_idcode();
    modes(1'h0, 1'h0, 1'h0);
    ctl.shift(1'h0, `SBST_ID_W, '0, q);
    chk("identity_word", q[31:0], ID);
    $display("test idcode done");
  endtask : t_idcode
  task automatic t_bypass();
    load_ir(`SBST_OP_BYPASS);
    ctl.shift(1'h0, 4, 4'hB, q);
    chk("one_bit_skip path", q[3:0], 4'h6);
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_sample();
    set_pins(PA);
    load_ir(`SBST_OP_SAMPLE);
    modes(1'h0, 1'h0, 1'h1);
    ctl.shift(1'h0, `SBST_BS_W, PB, q);
    chk("sample capture", q, PA);
    chk("preload", pin_drive, PB);
    $display("test sample done");
  endtask : t_sample
  task automatic t_extest();
    set_pins(PC);
    load_ir(`SBST_OP_EXTEST);
    modes(1'h1, 1'h0, 1'h1);
    chk("preloaded drive", pin_drive, PB);
    ctl.shift(1'h0, `SBST_BS_W, PA, q);
    chk("extest capture", q, PC);
    chk("extest vector", pin_drive, PA);
    $display("test extest done");
  endtask : t_extest
  task automatic t_sampz();
    set_pins(PB);
    load_ir(`SBST_OP_SAMPZ);
    modes(1'h0, 1'h1, 1'h1);
    ctl.shift(1'h0, `SBST_BS_W, PC, q);
    chk("sample-z capture", q, PB);
    $display("test sample-z done");
  endtask : t_sampz
  task automatic t_reset5();
    ctl.tlr();
    #400;
    t_idcode();
    $display("test mode_sel reset done");
  endtask : t_reset5
  // power-up again after extest, then let the memory clocks settle
  task automatic t_repower();
    load_ir(`SBST_OP_EXTEST);
    modes(1'h1, 1'h0, 1'h1);
    @(posedge sys_clk);
    rst_b <= 1'h0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (16) @(posedge sys_clk);
    #0.7;
    modes(1'h0, 1'h0, 1'h0);
    chk("pin_drive after power-up", pin_drive, '0);
    ctl.step(1'h0, 1'h1, o);
    t_idcode();
    $display("test power-up after extest done");
  endtask : t_repower

  initial begin
    rst_b = 1'h0;
    pin_level = '0;
    fails = 0;
    checked = 0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'h1;
    #0.7;
    ctl.step(1'h0, 1'h1, o);
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_sampz();
    t_reset5();
    t_repower();
    finish_test();
  end
  initial begin
    #200000;
    fails++;
    finish_test();
  end
endmodule : test_sbst_tap
